// ---- core/aphp_pkg.sv ----
// aphp_pkg: constants shared by the parallel host port of the data-acquisition converter.
// assumes a 10 MHz system clock; all pins are sampled into that domain.
package aphp_pkg;
    // ==========================================================
    // control byte fields
    localparam int unsigned CB_PD_HI   = 7;
    localparam int unsigned CB_PD_LO   = 6;
    localparam int unsigned CB_ACQ     = 5;
    localparam int unsigned CB_RNG     = 4;
    localparam int unsigned CB_BIP     = 3;
    localparam int unsigned CB_CH_HI   = 2;
    localparam logic [7:0]  CFG_RST    = 8'h00;
    localparam logic [1:0]  PD_EXT_CLK = 2'h0;
    localparam logic [1:0]  PD_INT_CLK = 2'h1;
    localparam logic [1:0]  PD_STANDBY = 2'h2;
    localparam logic [1:0]  PD_FULL    = 2'h3;
    // ==========================================================
    // timing and sizes
    localparam int unsigned ACQ_CYCLES  = 6;
    localparam int unsigned CONV_CYCLES = 12;
    localparam int unsigned RES_W       = 12;
    localparam int unsigned FIFO_DEPTH  = 8;
endpackage : aphp_pkg

// ---- core/aphp_fifo.sv ----
// aphp_fifo: small synchronous fifo with valid/ready on both sides.
// assumes one clock, synchronous active-high reset and a freezing clock enable.
`timescale 1ns/1ps
`default_nettype none
module aphp_fifo #(
    parameter int unsigned W = 12,
    parameter int unsigned D = 8
) (
    input  wire logic         clk_i,    // system clock
    input  wire logic         rst_i,    // sync reset
    input  wire logic         ce_i,     // clock enable
    input  wire logic         wvalid_i, // write request
    output logic              wready_o, // not full
    input  wire logic [W-1:0] wdata_i,  // write word
    output logic              rvalid_o, // not empty
    input  wire logic         rready_i, // read accept
    output logic      [W-1:0] rdata_o   // head word
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0]   cnt_r;
    wire           do_w = wvalid_i && wready_o;
    wire           do_r = rvalid_o && rready_i;
    assign wready_o = (cnt_r != (AW+1)'(D));
    assign rvalid_o = (cnt_r != '0);
    assign rdata_o  = mem_r[rp_r];
    // ==========================================================
    // pointers and storage; count moves by both sides at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (ce_i) begin
            if (do_w) begin
                mem_r[wp_r] <= wdata_i;
                wp_r        <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (do_r) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(do_w) - (AW+1)'(do_r);
        end
    end
endmodule : aphp_fifo
`default_nettype wire

// ---- core/aphp_core.sv ----
// aphp_core: parallel host port of an 8-channel 12-bit converter.
// assumes pins are asynchronous to clk_i; conversion core outside returns result words.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - internal acquisition: write rise with select low latches config, starts acquire+convert
// - external acquisition: first write rise starts acquiring selected input
// - external acquisition: second write rise with the acquisition bit clear ends tracking and starts conversion
// - read low with select low enables the data bus drivers
// - byte select high gives 4 msbs, low gives 8 lsbs
// - upper byte maps result 11..8 on lines 3..0; lower byte bits 7..0
// - power-off pin low forces deep sleep whatever the config says
// - completion flag goes low once a result is ready
// - select high ignores strobes and floats the bus
// - read falling edge returns completion flag high
// - internal acquisition holds input after 6 clock cycles
// - upper byte lines 7..4 are zero unipolar, msb copies bipolar
module aphp_core
    import aphp_pkg::*;
(
    input  wire logic                    clk_i,            // 10 MHz clock
    input  wire logic                    rst_i,            // sync reset
    input  wire logic                    ce_i,             // clock enable
    input  wire logic                    cs_n_i,           // chip select pin
    input  wire logic                    wr_n_i,           // write strobe pin
    input  wire logic                    rd_n_i,           // read strobe pin
    input  wire logic                    upper_byte_sel_i, // byte select pin
    input  wire logic                    power_off_n_i,    // shutdown pin
    input  wire logic [7:0]              bus_i,            // data bus in
    output logic      [7:0]              bus_o,            // data bus out
    output logic                         bus_oe_o,         // data bus drive
    output logic                         done_n_o,         // completion flag
    output logic                         track_o,          // track/hold tracking
    output logic                         convert_o,        // conversion running
    output logic      [2:0]              channel_o,        // selected input
    output logic      [1:0]              range_o,          // bip,rng
    output logic                         deep_sleep_o,     // full power-down
    output logic                         standby_o,        // standby power-down
    output logic                         int_clk_o,        // internal clock mode
    input  wire logic                    res_valid_i,      // result from core
    output logic                         res_ready_o,      // fifo can take it
    input  wire logic [aphp_pkg::RES_W-1:0] res_i          // result word
);
    import aphp_pkg::*;
    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_EXT, ST_CONV} aphp_st_t;
    // ==========================================================
    // pin synchronisers: three stages per pin, a level counts once stages two and three agree
    // bit order: 0 select, 1 write, 2 read, 3 byte select, 4 power-off, 12..5 data bus
    localparam int unsigned NPIN     = 13;
    localparam logic [12:0] PIN_IDLE = 13'h0017;   // select, strobes and power-off idle high, rest low
    wire  [NPIN-1:0] pin_raw = {bus_i, power_off_n_i, upper_byte_sel_i, rd_n_i, wr_n_i, cs_n_i};
    wire  [NPIN-1:0] pin_q;
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        logic [2:0] sync_r;
        logic       lvl_r;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sync_r <= {3{PIN_IDLE[g]}};
                lvl_r  <= PIN_IDLE[g];
            end else if (ce_i) begin
                sync_r <= {sync_r[1:0], pin_raw[g]};
                if (sync_r[1] == sync_r[2]) lvl_r <= sync_r[2];   // a one-sample glitch never gets through
            end
        end
        assign pin_q[g] = lvl_r;
    end
    wire       cs_q  = pin_q[0];
    wire       wr_q  = pin_q[1];
    wire       rd_q  = pin_q[2];
    wire       hb_q  = pin_q[3];
    wire       pw_q  = pin_q[4];
    wire [7:0] bus_q = pin_q[12:5];
    // ==========================================================
    // strobe edges, qualified by chip select; reset to idle levels so no false edge follows reset
    logic wr_d_r, rd_d_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_d_r <= 1'b1;
            rd_d_r <= 1'b1;
        end else if (ce_i) begin
            wr_d_r <= wr_q;
            rd_d_r <= rd_q;
        end
    end
    wire sel_w   = !cs_q;
    wire wr_rise = sel_w && wr_q && !wr_d_r;
    wire rd_fall = sel_w && !rd_q && rd_d_r;
    // ==========================================================
    // configuration byte from the filtered bus; the host must hold data and select
    // a few clocks past the write rise, since the edge is only seen after the filter
    logic [7:0] cfg_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) cfg_r <= CFG_RST;
        else if (ce_i && wr_rise) cfg_r <= bus_q;
    end
    wire [1:0] pd_w = cfg_r[CB_PD_HI:CB_PD_LO];
    assign deep_sleep_o = !pw_q || (pd_w == PD_FULL);
    assign standby_o    = pw_q && (pd_w == PD_STANDBY);
    assign int_clk_o    = (pd_w == PD_INT_CLK);          // external clock otherwise
    assign channel_o    = cfg_r[CB_CH_HI:0];
    assign range_o      = {cfg_r[CB_BIP], cfg_r[CB_RNG]};
    wire   new_ext_w    = bus_q[CB_ACQ];
    // ==========================================================
    // acquisition / conversion sequencer
    aphp_st_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            ST_IDLE: if (wr_rise && !deep_sleep_o) begin
                st_nxt  = new_ext_w ? ST_EXT : ST_ACQ;
                cnt_nxt = 4'(ACQ_CYCLES - 1);
            end
            ST_ACQ: if (cnt_r == 4'h0) begin
                st_nxt  = ST_CONV;
                cnt_nxt = 4'(CONV_CYCLES - 1);
            end else cnt_nxt = cnt_r - 4'h1;
            ST_EXT: if (wr_rise && !new_ext_w) begin
                st_nxt  = ST_CONV;
                cnt_nxt = 4'(CONV_CYCLES - 1);
            end
            ST_CONV: if (res_valid_i && res_ready_o) st_nxt = ST_IDLE;
        endcase
        if (deep_sleep_o) st_nxt = ST_IDLE;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r  <= ST_IDLE;
            cnt_r <= 4'h0;
        end else if (ce_i) begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign track_o     = (st_r == ST_ACQ) || (st_r == ST_EXT);
    assign convert_o   = (st_r == ST_CONV);
    // results only taken while converting; the fifo back-pressures the core
    wire   fifo_wready;
    // gated by the clock enable so a frozen fifo never loses a word the core thinks was taken
    assign res_ready_o = ce_i && convert_o && fifo_wready;
    // ==========================================================
    // result buffer; one word popped per read falling edge
    logic              rvalid;
    logic [RES_W-1:0]  head;
    aphp_fifo #(.W(RES_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .wvalid_i (res_valid_i && convert_o),
        .wready_o (fifo_wready),
        .wdata_i  (res_i),
        .rvalid_o (rvalid),
        .rready_i (rd_fall),
        .rdata_o  (head)
    );
    // ==========================================================
    // read data latch and completion flag
    logic [RES_W-1:0] rd_word_r;
    logic             done_n_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_word_r <= '0;
            done_n_r  <= 1'b1;
        end else if (ce_i) begin
            if (rd_fall && rvalid) rd_word_r <= head;
            done_n_r <= rd_fall ? 1'b1 : !rvalid;
        end
    end
    assign done_n_o = done_n_r;
    // byte mux: high byte sign- or zero-extends the 4 msbs
    wire       msb_fill = cfg_r[CB_BIP] & rd_word_r[RES_W-1];
    wire [7:0] hi_byte  = {{4{msb_fill}}, rd_word_r[11:8]};
    wire [7:0] lo_byte  = rd_word_r[7:0];
    logic [7:0] bus_r;
    logic       oe_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_r <= 8'h00;
            oe_r  <= 1'b0;
        end else if (ce_i) begin
            bus_r <= hb_q ? hi_byte : lo_byte;
            oe_r  <= sel_w && !rd_q;
        end
    end
    assign bus_o    = bus_r;
    assign bus_oe_o = oe_r;
    // ==========================================================
    // checks
    property p_oe_needs_cs;
        @(posedge clk_i) disable iff (rst_i) bus_oe_o |-> $past(!cs_q) && $past(!rd_q);
    endproperty
    a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("bus driven without select");
    property p_oe_on_read;
        @(posedge clk_i) disable iff (rst_i) (ce_i && !cs_q && !rd_q) |=> bus_oe_o;
    endproperty
    a_oe_on_read: assert property (p_oe_on_read) else $error("read did not drive bus");
    property p_sleep;
        @(posedge clk_i) disable iff (rst_i) !pw_q |-> deep_sleep_o ##1 (st_r == ST_IDLE || !$past(ce_i));
    endproperty
    a_sleep: assert property (p_sleep) else $error("shutdown not forced");
    property p_acq6;
        @(posedge clk_i) disable iff (rst_i || !ce_i || deep_sleep_o)
            (st_r == ST_IDLE && st_nxt == ST_ACQ) |=> (st_r == ST_ACQ)[*6] ##1 (st_r == ST_CONV);
    endproperty
    a_acq6: assert property (p_acq6) else $error("acquisition not 6 cycles");
    property p_ext_hold;
        @(posedge clk_i) disable iff (rst_i) (st_r == ST_EXT && !wr_rise && !deep_sleep_o) |=> st_r == ST_EXT;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("external acquire ended early");
    property p_rd_clears;
        @(posedge clk_i) disable iff (rst_i) (ce_i && rd_fall) |=> done_n_o;
    endproperty
    a_rd_clears: assert property (p_rd_clears) else $error("flag not cleared by read");
    property p_done;
        @(posedge clk_i) disable iff (rst_i) (ce_i && rvalid && !rd_fall) |=> !done_n_o;
    endproperty
    a_done: assert property (p_done) else $error("flag not set with result");
    property p_cfg_keep;
        @(posedge clk_i) disable iff (rst_i) !wr_rise |=> $stable(cfg_r);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("config changed without write");
    property p_upper;
        @(posedge clk_i) disable iff (rst_i) (ce_i && hb_q) |=> bus_o[3:0] == $past(rd_word_r[11:8]);
    endproperty
    a_upper: assert property (p_upper) else $error("upper byte wrong");
    c_int_acq:  cover property (@(posedge clk_i) st_r == ST_ACQ ##7 st_r == ST_CONV);
    c_ext_acq:  cover property (@(posedge clk_i) st_r == ST_EXT ##1 st_r == ST_CONV);
    c_read_hi:  cover property (@(posedge clk_i) bus_oe_o && hb_q);
    c_full:     cover property (@(posedge clk_i) !fifo_wready);
endmodule : aphp_core
`default_nettype wire

// ---- testbench/aphp_conv_model.sv ----
// aphp_conv_model: behavioural conversion core that hands result words to the port.
// assumes convert_i stays high while the port waits; lat_i sets how slowly it answers.
`timescale 1ns/1ps
`default_nettype none
module aphp_conv_model (
    input  wire logic        clk_i,     // bench clock, also the conversion clock
    input  wire logic        rst_i,     // sync reset
    input  wire logic        convert_i, // port is converting
    input  wire logic        ready_i,   // port accepts the word
    input  wire logic [7:0]  lat_i,     // cycles before the word is offered
    input  wire logic [11:0] word_i,    // word to hand over
    output logic             valid_o,   // word offered
    output logic      [11:0] data_o     // offered word
);
    logic [7:0]  cnt_r;
    logic [11:0] last_r;
    // ==========================================================
    // offer after lat_i cycles and hold until taken
    always_ff @(posedge clk_i) begin
        if (rst_i || !convert_i) begin
            cnt_r   <= 8'h00;
            valid_o <= 1'b0;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            last_r  <= word_i;
        end else if (!valid_o && cnt_r == lat_i) begin
            valid_o <= 1'b1;
        end else if (!valid_o) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // idle data is inverted so a stale word can never pass for a fresh one
    assign data_o = valid_o ? word_i : ~last_r;
endmodule : aphp_conv_model
`default_nettype wire

// ---- testbench/adc_parallel_host_port_test.sv ----
// adc_parallel_host_port_test: self-checking bench for the parallel host port.
// assumes the pin filters settle within 6 cycles; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module adc_parallel_host_port_test;
    import aphp_pkg::*;
    logic clk_i = 0, rst_i = 1, ce = 1, cs_n = 1, wr_n = 1, rd_n = 1, sel = 0, pwr_n = 1;
    logic [7:0] bus_i = 8'h00, bus_o, lat = 8'h03;
    logic oe, done_n, track, conv, dsl, stb, iclk, rv, rr;
    logic [2:0] ch;
    logic [1:0] rng;
    logic [11:0] word = 12'h000, rdat;
    int miscompares = 0, checked = 0, cycles = 0, trk = 0, n;
    always #50 clk_i = ~clk_i;
    aphp_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
        .upper_byte_sel_i(sel), .power_off_n_i(pwr_n), .bus_i(bus_i), .bus_o(bus_o), .bus_oe_o(oe),
        .done_n_o(done_n), .track_o(track), .convert_o(conv), .channel_o(ch), .range_o(rng),
        .deep_sleep_o(dsl), .standby_o(stb), .int_clk_o(iclk), .res_valid_i(rv), .res_ready_o(rr), .res_i(rdat));
    aphp_conv_model core (.clk_i(clk_i), .rst_i(rst_i), .convert_i(conv), .ready_i(rr), .lat_i(lat),
        .word_i(word), .valid_o(rv), .data_o(rdat));
    // ==========================================================
    // cycle ceiling and acquisition length counter
    always @(posedge clk_i) begin
        cycles++;
        if (track === 1'b1) trk++;
        if (cycles == 30000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask : cyc
    // host write: data and select held six clocks past the rise, as the port sees pins late
    task automatic wr(input logic [7:0] cfg, input logic sel_n);
        @(negedge clk_i);
        cs_n  = sel_n;
        bus_i = cfg;
        wr_n  = 1'b0;
        cyc(5);
        wr_n = 1'b1;
        cyc(6);
        cs_n  = 1'b1;
        bus_i = ~cfg;
    endtask : wr
    // wait, bounded, until the port is neither tracking nor converting
    task automatic idle(input int lim);
        for (n = 0; n < lim && (track !== 1'b0 || conv !== 1'b0); n++) cyc(1);
    endtask : idle
    // host read of both bytes inside one strobe
    task automatic rd(input logic [7:0] lo, input logic [7:0] hi);
        @(negedge clk_i);
        cs_n = 1'b0;
        sel  = 1'b0;
        rd_n = 1'b0;
        cyc(6);
        chk("bus_oe", 1, oe);
        chk("lower", lo, bus_o);
        sel = 1'b1;
        cyc(6);
        chk("upper", hi, bus_o);
        rd_n = 1'b1;
        cs_n = 1'b1;
        cyc(6);
        chk("bus_oe_off", 0, oe);
    endtask : rd
    task automatic t_internal();
        word = 12'hA5C;
        trk  = 0;
        wr(8'h1D, 1'b0);
        idle(100);
        chk("track_len", 6, trk[11:0]);
        chk("channel", 5, ch);
        chk("range", 2'h3, rng);
        cyc(3);
        chk("done_low", 0, done_n);
        rd(8'h5C, 8'hFA);
        chk("done_high", 1, done_n);
    endtask : t_internal
    // clock enable low in mid-acquisition freezes the sequencer, which then resumes
    task automatic t_freeze();
        word = 12'h3C7;
        wr(8'h00, 1'b0);
        ce = 1'b0;
        cyc(20);
        chk("frz_track", 1, track);
        chk("frz_conv", 0, conv);
        ce = 1'b1;
        idle(60);
        cyc(2);
        chk("frz_done", 0, done_n);
        rd(8'hC7, 8'h03);
    endtask : t_freeze
    task automatic t_external();
        word = 12'h8F3;
        lat  = 8'h14;
        wr(8'h22, 1'b0);
        cyc(30);
        chk("ext_track", 1, track);
        chk("ext_conv", 0, conv);
        wr(8'h02, 1'b0);
        chk("ext_hold", 0, track);
        idle(100);
        cyc(2);
        chk("ext_done", 0, done_n);
        rd(8'hF3, 8'h08);
        lat = 8'h03;
    endtask : t_external
    task automatic t_deselect();
        wr(8'h07, 1'b1);
        cyc(10);
        chk("cs_track", 0, track);
        chk("cs_channel", 2, ch);
        @(negedge clk_i);
        rd_n = 1'b0;
        cyc(8);
        chk("cs_oe", 0, oe);
        rd_n = 1'b1;
    endtask : t_deselect
    // nine conversions into an eight word buffer, then drain with the core stalling
    task automatic t_fill();
        for (int k = 0; k < 9; k++) begin
            word = 12'h100 + 12'(k);
            wr(8'h00, 1'b0);
            idle(60);
        end
        chk("full_conv", 1, conv);
        chk("full_ready", 0, rr);
        lat = 8'h10;
        for (int k = 0; k < 9; k++) rd(8'(k), 8'h01);
        cyc(3);
        chk("drained", 1, done_n);
        lat = 8'h03;
    endtask : t_fill
    // the power-off pin is pulled while an acquisition runs, so the forced stop is visible
    task automatic t_power();
        wr(8'h00, 1'b0);
        pwr_n = 1'b0;
        cyc(6);
        chk("pin_sleep", 1, dsl);
        chk("sleep_abort", 0, conv);
        chk("sleep_track", 0, track);
        pwr_n = 1'b1;
        wr(8'h40, 1'b0);
        chk("int_clk", 1, iclk);
        chk("awake", 0, dsl);
        idle(60);
        wr(8'h80, 1'b0);
        chk("standby", 1, stb);
        idle(60);
        wr(8'hC0, 1'b0);
        chk("cfg_sleep", 1, dsl);
        cyc(8);
        chk("sleep_idle", 0, track);
    endtask : t_power
    initial begin
        cyc(2);
        rst_i = 1'b0;
        cyc(6);
        chk("rst_done", 1, done_n);
        chk("rst_oe", 0, oe);
        t_internal();
        t_freeze();
        t_external();
        t_deselect();
        t_fill();
        t_power();
        complete_run();
    end
endmodule : adc_parallel_host_port_test
`default_nettype wire
